// ==== hdl/mlbs_lane_map.sv ====
// Combinational lane cutter for one half of the multiplier array
`timescale 1ns/10ps
`include "mlbs_params.svh"

module mlbs_lane_map
	import mlbs_pkg::*;
(
	input  wire logic [`MLBS_BUS_W-1:0] bus_a,
	input  wire logic [`MLBS_BUS_W-1:0] bus_b,
	input  wire logic [`MLBS_SEL_W-1:0] sel,
	input  wire logic                   upper,
	output mlbs_half_t                  lanes,
	output logic [`MLBS_HALF-1:0]       active,
	output logic                        map_ok
);

	// ----------------------------------------------------------------
	// Selector decode
	// ----------------------------------------------------------------
	// Upper half treats the low-half Int8 x1/x2 and Int7 x1 codes as unused
	function automatic mlbs_map_s decode(
		input logic [`MLBS_SEL_W-1:0] code,
		input logic                   up
	);
		mlbs_map_s m;
		m = '0;
		m.fmt = MLBS_FMT_NONE;
		if (!up) begin
			case (code)
				`MLBS_C_I8_X1: begin
					m = '{1'b1, MLBS_FMT_INT8, `MLBS_N_I8_X1,
						`MLBS_P_ZERO, `MLBS_P_I8_B};
				end
				`MLBS_C_I8_X2: begin
					m = '{1'b1, MLBS_FMT_INT8, `MLBS_N_FULL,
						`MLBS_P_ZERO, `MLBS_P_ZERO};
				end
				`MLBS_C_I7_X1: begin
					m = '{1'b1, MLBS_FMT_INT7, `MLBS_N_I7_X1,
						`MLBS_P_ZERO, `MLBS_P_I7_B};
				end
				`MLBS_C_I7_X2: begin
					m = '{1'b1, MLBS_FMT_INT7, `MLBS_N_FULL,
						`MLBS_P_ZERO, `MLBS_P_ZERO};
				end
				default: m.ok = 1'b0;
			endcase
		end else begin
			case (code)
				`MLBS_C_I8_X1, `MLBS_C_I8_X2, `MLBS_C_I7_X1: begin
					m.ok = 1'b1;
				end
				`MLBS_C_I7_X2: begin
					m = '{1'b1, MLBS_FMT_INT7, `MLBS_N_I7_X2H,
						`MLBS_P_I7_X2H, `MLBS_P_I7_X2H};
				end
				`MLBS_C_I8_SPH: begin
					m = '{1'b1, MLBS_FMT_INT8, `MLBS_N_I8_X1,
						`MLBS_P_ZERO, `MLBS_P_I8_B};
				end
				`MLBS_C_I8_X4H: begin
					m = '{1'b1, MLBS_FMT_INT8, `MLBS_N_FULL,
						`MLBS_P_ZERO, `MLBS_P_ZERO};
				end
				`MLBS_C_I7_SPH: begin
					m = '{1'b1, MLBS_FMT_INT7, `MLBS_N_I7_X1,
						`MLBS_P_ZERO, `MLBS_P_I7_B};
				end
				`MLBS_C_I7_X4H: begin
					m = '{1'b1, MLBS_FMT_INT7, `MLBS_N_FULL,
						`MLBS_P_ZERO, `MLBS_P_ZERO};
				end
				default: m.ok = 1'b0;
			endcase
		end
		return m;
	endfunction

	// lane width follows format
	// Cut one lane, narrow lanes are zero extended
	function automatic logic [`MLBS_OP_W-1:0] cut(
		input logic [`MLBS_BUS_W-1:0] bus,
		input logic [`MLBS_POS_W-1:0] pos,
		input logic                   narrow
	);
		logic [`MLBS_BUS_W-1:0] sh;
		sh = bus >> pos;
		return narrow ? {1'b0, sh[`MLBS_W7-1:0]} : sh[`MLBS_OP_W-1:0];
	endfunction

	// ----------------------------------------------------------------
	// Lane routing
	// ----------------------------------------------------------------
	mlbs_map_s              m;
	logic [`MLBS_POS_W-1:0] width;

	assign m      = decode(sel, upper);
	assign map_ok = m.ok;
	assign width  = (m.fmt == MLBS_FMT_INT7) ? `MLBS_POS_W'(`MLBS_W7)
		: `MLBS_POS_W'(`MLBS_W8);

	// cut from full-width buses
	// Lanes past the count stay zero so idle multipliers see no data
	always_comb begin
		logic [`MLBS_POS_W-1:0] step;
		step = '0;
		for (int i = 0; i < `MLBS_HALF; i++) begin
			active[i] = (`MLBS_CNT_W'(i) < m.count);
			lanes[i].a = active[i] ? cut(bus_a, m.a_base + step,
				m.fmt == MLBS_FMT_INT7) : '0;
			lanes[i].b = active[i] ? cut(bus_b, m.b_base + step,
				m.fmt == MLBS_FMT_INT7) : '0;
			step = step + width;
		end
	end

endmodule

// ==== hdl/mlbs_params.svh ====
// Constants for the multiplier lane byte select block
`ifndef MLBS_PARAMS_SVH
`define MLBS_PARAMS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define MLBS_BUS_W     72
`define MLBS_OP_W      8
`define MLBS_HALF      8
`define MLBS_MULTS     16
`define MLBS_POS_W     7
`define MLBS_CNT_W     4
`define MLBS_SEL_W     8
`define MLBS_W8        8
`define MLBS_W7        7

// ----------------------------------------------------------------
// Lane selector codes
// ----------------------------------------------------------------
`define MLBS_C_I8_X1   8'h00
`define MLBS_C_I8_X2   8'h01
`define MLBS_C_I8_SPH  8'h20
`define MLBS_C_I8_X4H  8'h21
`define MLBS_C_I7_X1   8'h07
`define MLBS_C_I7_X2   8'h08
`define MLBS_C_I7_SPH  8'h27
`define MLBS_C_I7_X4H  8'h28

// ----------------------------------------------------------------
// Lane counts and bit positions
// ----------------------------------------------------------------
`define MLBS_N_I8_X1   4'h4
`define MLBS_N_FULL    4'h8
`define MLBS_N_I7_X1   4'h5
`define MLBS_N_I7_X2H  4'h2
`define MLBS_P_ZERO    7'h00
`define MLBS_P_I8_B    7'h20
`define MLBS_P_I7_B    7'h23
`define MLBS_P_I7_X2H  7'h38

`endif

// ==== hdl/mlbs_pkg.sv ====
// Types shared by the multiplier lane byte select block
`include "mlbs_params.svh"

package mlbs_pkg;

	// Number format of one half
	typedef enum logic [1:0] {
		MLBS_FMT_NONE,
		MLBS_FMT_INT8,
		MLBS_FMT_INT7
	} mlbs_fmt_e;

	// Operand pair for one multiplier
	typedef struct packed {
		logic [`MLBS_OP_W-1:0] a;
		logic [`MLBS_OP_W-1:0] b;
	} mlbs_pair_s;

	// Four selected operand buses
	typedef struct packed {
		logic [`MLBS_BUS_W-1:0] hi_b;
		logic [`MLBS_BUS_W-1:0] hi_a;
		logic [`MLBS_BUS_W-1:0] lo_b;
		logic [`MLBS_BUS_W-1:0] lo_a;
	} mlbs_buses_s;

	// Decoded lane layout of one half
	typedef struct packed {
		logic                   ok;
		mlbs_fmt_e              fmt;
		logic [`MLBS_CNT_W-1:0] count;
		logic [`MLBS_POS_W-1:0] a_base;
		logic [`MLBS_POS_W-1:0] b_base;
	} mlbs_map_s;

	typedef mlbs_pair_s [`MLBS_HALF-1:0]  mlbs_half_t;
	typedef mlbs_pair_s [`MLBS_MULTS-1:0] mlbs_ops_t;

endpackage

// ==== hdl/mlbs_top.sv ====
// Integer lane selection feeding sixteen multipliers
`timescale 1ns/10ps
`include "mlbs_params.svh"

// Notes on behaviour
// - Up to sixteen integer products per cycle
// - Buses cut into format-wide lanes
// - Low buses feed 7..0, high 15..8
// - Two selectors are fully independent
// - Widened modes change only upper selector
// - One source bus may carry both operands
// - Int8 and Int7 reach sixteen multipliers
// - Int8 x1: four lanes from low buses
// - Int8 x2: eight lanes from low buses
// - Int8 x4: eight more from high buses
// - Int8 split: four lanes per half
// - Int7 x1: five seven-bit lanes
// - Int7 x2: ten lanes, two from high
// - Int7 x4: eight more from high buses
// - Int7 split: five lanes per half
// - Each operand bus is 72 bits
module mlbs_top
	import mlbs_pkg::*;
#(
	parameter logic [`MLBS_SEL_W-1:0] LO_SEL = `MLBS_C_I8_X1,
	parameter logic [`MLBS_SEL_W-1:0] HI_SEL = `MLBS_C_I8_X1
) (
	input  wire logic              clock,
	input  wire logic              reset_n,
	input  wire logic              in_valid,
	input  wire mlbs_buses_s       buses,
	output logic                   out_valid,
	output mlbs_ops_t              ops,
	output logic [`MLBS_MULTS-1:0] active,
	output logic                   map_ok
);

	// ----------------------------------------------------------------
	// Lane routing for both halves
	// ----------------------------------------------------------------
	mlbs_half_t             lo_lanes;
	mlbs_half_t             hi_lanes;
	logic [`MLBS_HALF-1:0]  lo_act;
	logic [`MLBS_HALF-1:0]  hi_act;
	logic                   lo_ok;
	logic                   hi_ok;
	mlbs_ops_t              ops_r;
	logic [`MLBS_MULTS-1:0] active_r;
	logic                   valid_r;
	logic                   map_ok_r;

	// both operands may share one bus
	mlbs_lane_map u_lo (
		.bus_a  (buses.lo_a),
		.bus_b  (buses.lo_b),
		.sel    (LO_SEL),
		.upper  (1'b0),
		.lanes  (lo_lanes),
		.active (lo_act),
		.map_ok (lo_ok)
	);

	// separate selector for the upper half
	mlbs_lane_map u_hi (
		.bus_a  (buses.hi_a),
		.bus_b  (buses.hi_b),
		.sel    (HI_SEL),
		.upper  (1'b1),
		.lanes  (hi_lanes),
		.active (hi_act),
		.map_ok (hi_ok)
	);

	// ----------------------------------------------------------------
	// Output registers
	// ----------------------------------------------------------------
	// sixteen operand pairs, one per lane
	// operands held when no new data arrives
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			ops_r <= '0;
		end else if (in_valid) begin
			ops_r <= {hi_lanes, lo_lanes};
		end
	end

	// Lane-in-use mask and code check follow the static selectors
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			active_r <= '0;
			map_ok_r <= 1'b0;
		end else begin
			active_r <= {hi_act, lo_act};
			map_ok_r <= lo_ok & hi_ok;
		end
	end

	// Valid follows data by one register stage
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			valid_r <= 1'b0;
		end else begin
			valid_r <= in_valid;
		end
	end

	assign ops       = ops_r;
	assign active    = active_r;
	assign out_valid = valid_r;
	assign map_ok    = map_ok_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);

	// Codes each half accepts; anything else must leave that half idle
	localparam logic LO_LISTED = (LO_SEL == `MLBS_C_I8_X1) ||
		(LO_SEL == `MLBS_C_I8_X2) || (LO_SEL == `MLBS_C_I7_X1) ||
		(LO_SEL == `MLBS_C_I7_X2);
	localparam logic HI_LISTED = (HI_SEL == `MLBS_C_I8_X1) ||
		(HI_SEL == `MLBS_C_I8_X2) || (HI_SEL == `MLBS_C_I7_X1) ||
		(HI_SEL == `MLBS_C_I7_X2) || (HI_SEL == `MLBS_C_I8_SPH) ||
		(HI_SEL == `MLBS_C_I8_X4H) || (HI_SEL == `MLBS_C_I7_SPH) ||
		(HI_SEL == `MLBS_C_I7_X4H);

	// Input copy for comparing against the registered lanes
	mlbs_buses_s buses_q;

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			buses_q <= '0;
		end else begin
			buses_q <= buses;
		end
	end

	sequence s_take;
		in_valid;
	endsequence

	sequence s_held;
		!in_valid ##1 1'b1;
	endsequence

	// out_valid rises one cycle after data is taken
	a_valid_follow: assert property (
		s_take |=> out_valid ##1 (out_valid == $past(in_valid))
	) else $error("out_valid does not follow in_valid");

	a_ops_held: assert property (
		s_held |-> $stable(ops)
	) else $error("operands changed without in_valid");

	a_int8_x1_map: assert property (
		(LO_SEL == `MLBS_C_I8_X1) && in_valid |=>
			ops[3].a == buses_q.lo_a[3*`MLBS_W8 +: `MLBS_W8] &&
			ops[0].b == buses_q.lo_b[4*`MLBS_W8 +: `MLBS_W8] &&
			ops[3].b == buses_q.lo_b[7*`MLBS_W8 +: `MLBS_W8] &&
			ops[4].a == '0 && active[7:0] == 8'h0f
	) else $error("Int8 x1 lane mapping wrong");

	a_int8_x2_map: assert property (
		(LO_SEL == `MLBS_C_I8_X2) && in_valid |=>
			ops[7].a == buses_q.lo_a[7*`MLBS_W8 +: `MLBS_W8] &&
			ops[7].b == buses_q.lo_b[7*`MLBS_W8 +: `MLBS_W8] &&
			ops[0].b == buses_q.lo_b[0 +: `MLBS_W8] &&
			active[7:0] == 8'hff
	) else $error("Int8 x2 lane mapping wrong");

	a_int8_x4_high: assert property (
		(HI_SEL == `MLBS_C_I8_X4H) && in_valid |=>
			ops[15].a == buses_q.hi_a[7*`MLBS_W8 +: `MLBS_W8] &&
			ops[8].b == buses_q.hi_b[0 +: `MLBS_W8] &&
			active[15:8] == 8'hff
	) else $error("Int8 x4 upper mapping wrong");

	a_int8_split_high: assert property (
		(HI_SEL == `MLBS_C_I8_SPH) && in_valid |=>
			ops[11].a == buses_q.hi_a[3*`MLBS_W8 +: `MLBS_W8] &&
			ops[8].b == buses_q.hi_b[4*`MLBS_W8 +: `MLBS_W8] &&
			ops[12].a == '0 && active[15:8] == 8'h0f
	) else $error("Int8 split upper mapping wrong");

	a_int7_x1_map: assert property (
		(LO_SEL == `MLBS_C_I7_X1) && in_valid |=>
			ops[4].a == {1'b0, buses_q.lo_a[4*`MLBS_W7 +: `MLBS_W7]} &&
			ops[0].b == {1'b0, buses_q.lo_b[5*`MLBS_W7 +: `MLBS_W7]} &&
			ops[4].b == {1'b0, buses_q.lo_b[9*`MLBS_W7 +: `MLBS_W7]} &&
			active[7:0] == 8'h1f
	) else $error("Int7 x1 lane mapping wrong");

	// Int7 x2 takes two lanes from the high buses
	a_int7_x2_high: assert property (
		(LO_SEL == `MLBS_C_I7_X2) && (HI_SEL == `MLBS_C_I7_X2)
			&& in_valid |=>
			ops[7].a == {1'b0, buses_q.lo_a[7*`MLBS_W7 +: `MLBS_W7]} &&
			ops[8].a == {1'b0, buses_q.hi_a[8*`MLBS_W7 +: `MLBS_W7]} &&
			ops[9].b == {1'b0, buses_q.hi_b[9*`MLBS_W7 +: `MLBS_W7]} &&
			active == 16'h03ff
	) else $error("Int7 x2 mapping wrong");

	a_int7_x4_high: assert property (
		(HI_SEL == `MLBS_C_I7_X4H) && in_valid |=>
			ops[15].a == {1'b0, buses_q.hi_a[7*`MLBS_W7 +: `MLBS_W7]} &&
			ops[8].b == {1'b0, buses_q.hi_b[0 +: `MLBS_W7]} &&
			active[15:8] == 8'hff
	) else $error("Int7 x4 upper mapping wrong");

	a_int7_split_high: assert property (
		(HI_SEL == `MLBS_C_I7_SPH) && in_valid |=>
			ops[12].a == {1'b0, buses_q.hi_a[4*`MLBS_W7 +: `MLBS_W7]} &&
			ops[8].b == {1'b0, buses_q.hi_b[5*`MLBS_W7 +: `MLBS_W7]} &&
			active[15:8] == 8'h1f
	) else $error("Int7 split upper mapping wrong");

	// upper half idle under low-only codes
	a_high_unused: assert property (
		((HI_SEL == `MLBS_C_I8_X1) || (HI_SEL == `MLBS_C_I8_X2) ||
			(HI_SEL == `MLBS_C_I7_X1)) && in_valid |=>
			ops[15:8] == '0 && active[15:8] == '0 &&
			map_ok == LO_LISTED
	) else $error("upper half not idle");

	// each half fills its multipliers from the bottom
	a_lane_count: assert property (
		out_valid |-> $countones(active) <= `MLBS_MULTS &&
			((active[7:0] & (active[7:0] + 8'h01)) == 8'h00) &&
			((active[15:8] & (active[15:8] + 8'h01)) == 8'h00) &&
			(map_ok || active[7:0] == 8'h00 || active[15:8] == 8'h00)
	) else $error("active lanes not packed from the bottom");

	// code check follows the static selectors
	a_map_ok_codes: assert property (
		in_valid |=> map_ok == (LO_LISTED && HI_LISTED)
	) else $error("map_ok disagrees with the selector codes");

	// rejected lower code leaves the half idle
	a_unlisted_zero: assert property (
		!LO_LISTED && in_valid |=>
			ops[7:0] == '0 && active[7:0] == '0
	) else $error("unlisted lower code reached a lane");

	// mask and code check never move once running
	a_active_static: assert property (
		out_valid && $past(reset_n, 2) |->
			$stable(active) && $stable(map_ok)
	) else $error("lane mask changed while running");

	// one word carries both operands in x1
	a_shared_bus: assert property (
		(LO_SEL == `MLBS_C_I8_X1) && in_valid &&
			(buses.lo_a == buses.lo_b) |=>
			ops[0].a == buses_q.lo_a[0 +: `MLBS_W8] &&
			ops[0].b == buses_q.lo_a[4*`MLBS_W8 +: `MLBS_W8] &&
			ops[3].b == buses_q.lo_a[7*`MLBS_W8 +: `MLBS_W8]
	) else $error("shared operand word cut wrongly");

	// Int8 x4 keeps the x2 lower half
	a_int8_x4_low: assert property (
		(LO_SEL == `MLBS_C_I8_X2) && (HI_SEL == `MLBS_C_I8_X4H)
			&& in_valid |=>
			ops[7].b == buses_q.lo_b[7*`MLBS_W8 +: `MLBS_W8] &&
			ops[12].b == buses_q.hi_b[4*`MLBS_W8 +: `MLBS_W8] &&
			active == 16'hffff
	) else $error("Int8 x4 lower mapping wrong");

	// Int8 split keeps four lanes per half
	a_int8_split_low: assert property (
		(LO_SEL == `MLBS_C_I8_X1) && (HI_SEL == `MLBS_C_I8_SPH)
			&& in_valid |=>
			ops[3].b == buses_q.lo_b[7*`MLBS_W8 +: `MLBS_W8] &&
			ops[11].b == buses_q.hi_b[7*`MLBS_W8 +: `MLBS_W8] &&
			active == 16'h0f0f
	) else $error("Int8 split mapping wrong");

	// Int7 x4 keeps the x2 lower half
	a_int7_x4_low: assert property (
		(LO_SEL == `MLBS_C_I7_X2) && (HI_SEL == `MLBS_C_I7_X4H)
			&& in_valid |=>
			ops[0].a == {1'b0, buses_q.lo_a[0 +: `MLBS_W7]} &&
			ops[7].b == {1'b0, buses_q.lo_b[7*`MLBS_W7 +: `MLBS_W7]} &&
			ops[12].a == {1'b0, buses_q.hi_a[4*`MLBS_W7 +: `MLBS_W7]} &&
			active == 16'hffff
	) else $error("Int7 x4 mapping wrong");

	// Int7 split keeps five lanes per half
	a_int7_split_low: assert property (
		(LO_SEL == `MLBS_C_I7_X1) && (HI_SEL == `MLBS_C_I7_SPH)
			&& in_valid |=>
			ops[4].a == {1'b0, buses_q.lo_a[4*`MLBS_W7 +: `MLBS_W7]} &&
			ops[12].b == {1'b0, buses_q.hi_b[9*`MLBS_W7 +: `MLBS_W7]} &&
			active == 16'h1f1f
	) else $error("Int7 split mapping wrong");

	// seven-bit lanes leave the top operand bit clear
	a_int7_zext: assert property (
		((LO_SEL == `MLBS_C_I7_X1) || (LO_SEL == `MLBS_C_I7_X2))
			&& in_valid |=>
			ops[0].a[`MLBS_W7] == 1'b0 && ops[4].b[`MLBS_W7] == 1'b0
	) else $error("Int7 lane not zero extended");

endmodule

// ==== verif/mlbs_fabric_drv.sv ====
// Fabric-side model that packs operands onto the four operand buses
`timescale 1ns/10ps

module mlbs_fabric_drv
	import mlbs_pkg::*;
#(
	parameter logic [7:0] LO_SEL = 8'h00,
	parameter logic [7:0] HI_SEL = 8'h00
) (
	input  wire logic [7:0] k,
	input  wire logic       vld,
	output logic            in_valid,
	output mlbs_buses_s     buses,
	output mlbs_ops_t       sent
);
	// ------------------------------------------------------------
	// Lane packing, one half at a time
	// ------------------------------------------------------------
	logic [7:0]  code;
	logic [7:0]  m;
	logic [7:0]  av;
	logic [7:0]  bv;
	logic [71:0] wa;
	logic [71:0] wb;
	logic        ok;
	int          w;
	int          n;
	int          ab;
	int          bb;

	// Sent is what each multiplier must see; zero where unused
	always_comb begin
		sent = '0;
		buses = '0;
		for (int h = 0; h < 2; h++) begin
			code = (h == 1) ? HI_SEL : LO_SEL;
			n = 0;
			ab = 0;
			ok = 1'b1;
			// two upper Int7 lanes at 69:56
			if (h == 1 && code == 8'h08) begin
				n = 2;
				ab = 56;
			end else if (h == 0 || code[5]) begin
				ok = !(h == 0 && code[5]);
				case (code & 8'hdf)
				8'h00: n = 4;
				8'h01: n = 8;
				8'h07: n = 5;
				8'h08: n = 8;
				default: ok = 1'b0;
				endcase
			end
			w = (code[3:0] >= 4'h7) ? 7 : 8;
			bb = (n == 4) ? 32 : (n == 5) ? 35 : ab;
			m = (w == 7) ? 8'h7f : 8'hff;
			if (!ok) begin
				n = 0;
			end
			wa = '0;
			wb = '0;
			for (int i = 0; i < n; i++) begin
				av = 8'(k + 3 * (h * 8 + i) + 1) & m;
				bv = 8'(5 * k + 7 * (h * 8 + i) + 2) & m;
				for (int j = 0; j < w; j++) begin
					wa[ab + i * w + j] = av[j];
					wb[bb + i * w + j] = bv[j];
				end
				sent[h * 8 + i] = {av, bv};
			end
			if (ab != bb) begin
				wa = wa | wb;
				wb = wa;
			end
			// Unlisted code: junk on the wire must never reach a lane
			if (!ok) begin
				wa = {9{8'ha5}};
				wb = ~wa;
			end
			if (h == 0) begin
				buses.lo_a = wa;
				buses.lo_b = wb;
			end else begin
				buses.hi_a = wa;
				buses.hi_b = wb;
			end
		end
		// Idle buses show the inverse, so stale capture is caught
		if (!vld) begin
			buses = ~buses;
		end
		in_valid = vld;
	end
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench: each mode's selector pairing side by side
`timescale 1ns/10ps

module tb_top
	import mlbs_pkg::*;
;
	// ------------------------------------------------------------
	// Mode table; last entry puts an upper-only code on the lower half
	// ------------------------------------------------------------
	localparam int NM = 9;
	localparam logic [7:0] LO_T [NM] = '{8'h00, 8'h01, 8'h01, 8'h00,
		8'h07, 8'h08, 8'h08, 8'h07, 8'h20};
	localparam logic [7:0] HI_T [NM] = '{8'h00, 8'h01, 8'h21, 8'h20,
		8'h07, 8'h08, 8'h28, 8'h27, 8'h00};
	localparam int NLO [NM] = '{4, 8, 8, 4, 5, 8, 8, 5, 0};
	localparam int NHI [NM] = '{0, 0, 8, 4, 0, 2, 8, 5, 0};

	logic        clock;
	logic        reset_n;
	logic [7:0]  k;
	logic        vld;
	logic        in_v    [NM];
	mlbs_buses_s bus     [NM];
	mlbs_ops_t   sent    [NM];
	mlbs_ops_t   exp_ops [NM];
	logic        out_v   [NM];
	mlbs_ops_t   ops     [NM];
	logic [15:0] act     [NM];
	logic        ok      [NM];
	int          mismatches = 0;
	int          n_checks = 0;

	// One driver and one block per mode
	for (genvar g = 0; g < NM; g++) begin : g_mode
		mlbs_fabric_drv #(.LO_SEL(LO_T[g]), .HI_SEL(HI_T[g]))
		i_mlbs_fabric_drv (.k(k), .vld(vld), .in_valid(in_v[g]),
			.buses(bus[g]), .sent(sent[g]));
		mlbs_top #(.LO_SEL(LO_T[g]), .HI_SEL(HI_T[g])) i_mlbs_top (
			.clock(clock), .reset_n(reset_n), .in_valid(in_v[g]),
			.buses(bus[g]), .out_valid(out_v[g]), .ops(ops[g]),
			.active(act[g]), .map_ok(ok[g]));
	end

	// ------------------------------------------------------------
	// Clock and helpers
	// ------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	task automatic chk(input string what, input logic [287:0] e,
		input logic [287:0] s);
		n_checks++;
		if (s !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, e, s);
		end
	endtask

	function automatic logic [15:0] exp_act(input int g);
		return 16'((1 << NLO[g]) - 1) | 16'(((1 << NHI[g]) - 1) << 8);
	endfunction

	task automatic check_all(input logic ev);
		for (int g = 0; g < NM; g++) begin
			chk($sformatf("out_valid m%0d", g), ev, out_v[g]);
			chk($sformatf("ops m%0d", g), exp_ops[g], ops[g]);
			chk($sformatf("active m%0d", g), exp_act(g), act[g]);
			chk($sformatf("map_ok m%0d", g), g < NM - 1, ok[g]);
		end
	endtask

	task automatic chk_zero();
		for (int g = 0; g < NM; g++) begin
			chk($sformatf("reset m%0d", g), '0,
				{out_v[g], ok[g], act[g], ops[g]});
		end
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	// Back-to-back transfers, new operands on every edge
	task automatic t_stream(input logic [7:0] k0);
		for (int t = 0; t <= 4; t++) begin
			@(posedge clock);
			#1;
			if (t > 0) check_all(1'b1);
			k = 8'(k0 + t * 8'h31);
			vld = (t < 4);
			#1;
			for (int g = 0; g < NM; g++) begin
				if (vld) exp_ops[g] = sent[g];
			end
		end
	endtask

	// Idle cycles leave lanes untouched though the buses move
	task automatic t_hold();
		repeat (2) begin
			@(posedge clock);
			#1;
			check_all(1'b0);
		end
	endtask

	// Reset in mid-run with a transfer offered
	task automatic t_reset_mid();
		@(posedge clock);
		#1;
		reset_n = 1'b0;
		vld = 1'b1;
		repeat (2) begin
			@(posedge clock);
			#1;
			chk_zero();
		end
		reset_n = 1'b1;
		vld = 1'b0;
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Run is about 25 cycles; this cuts a hang well after that
	initial begin
		#2000;
		mismatches++;
		tally_and_finish();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		reset_n = 1'b0;
		k = 8'h00;
		vld = 1'b0;
		repeat (8) @(posedge clock);
		#1;
		chk_zero();
		reset_n = 1'b1;
		t_stream(8'h10);
		t_hold();
		t_reset_mid();
		t_stream(8'hfc);
		t_hold();
		tally_and_finish();
	end
endmodule
